/* cad_defs.svh */
// Constants for the cartridge management bus address decoder.
// Assumes inclusion by bare name from the matcher and top-level modules.
`ifndef CAD_DEFS_SVH
`define CAD_DEFS_SVH

`define CAD_MEM_UPPER      4'hA
`define CAD_TS_UPPER_LOW   4'h3
`define CAD_TS_UPPER_FLOAT 4'h5
`define CAD_TS_UPPER_HIGH  4'h9
`define CAD_CMD_RESET      8'h00
`define CAD_BYTE_BITS      4'h8
`define CAD_STRAP_SETTLE   2'h3
`define CAD_RW_BIT         0
`define CAD_UPPER_MSB      7
`define CAD_UPPER_LSB      4
`define CAD_SEL_LOW        2'h0
`define CAD_SEL_FLOAT      2'h1
`define CAD_SEL_HIGH       2'h2

`endif

/* cad_pkg.sv */
// Types shared by the cartridge management bus address decoder.
// Assumes cad_defs.svh is reachable on the include path.
`default_nettype none
package cad_pkg;
   // Three-state select as reported by the pad: low, floating, high.
   typedef logic [1:0] cad_tsel_t;

   // Which on-cartridge component claimed the address byte.
   typedef struct packed {
      logic scratch;
      logic info;
      logic sensor;
   } cad_match_t;

   typedef enum logic [2:0] {
      CAD_IDLE = 3'h0,
      CAD_ADDR = 3'h1,
      CAD_ACK  = 3'h3,
      CAD_DATA = 3'h2,
      CAD_CACK = 3'h6,
      CAD_WAIT = 3'h4
   } cad_state_t;
endpackage
`default_nettype wire

/* cad_addr_match.sv */
// Address comparator for the two memory components and the thermal sensor.
// Assumes stable select levels; purely combinational.
`include "cad_defs.svh"
`default_nettype none
module cad_addr_match (
   // Received address byte
   input  wire logic [7:0]         addr_byte,
   // Live memory slot selects
   input  wire logic               slot_select_high,
   input  wire logic               slot_select_low,
   // Sensor selects captured at power up
   input  wire cad_pkg::cad_tsel_t sensor_sel_cap,
   input  wire logic               sensor_slot_cap,
   // Result
   output cad_pkg::cad_match_t     match
);
   import cad_pkg::*;

   logic [6:0] mem_base;
   logic [3:0] ts_upper;
   logic [6:0] ts_addr;
   logic       ts_known;

   always_comb begin
      // The direction bit never takes part in the compare.
      mem_base = {`CAD_MEM_UPPER, slot_select_high, slot_select_low, 1'b0}; // RULE_01 RULE_03
      unique case (sensor_sel_cap)
         `CAD_SEL_LOW: begin
            ts_upper = `CAD_TS_UPPER_LOW;
            ts_known = 1'b1;
         end
         `CAD_SEL_FLOAT: begin
            ts_upper = `CAD_TS_UPPER_FLOAT;
            ts_known = 1'b1;
         end
         `CAD_SEL_HIGH: begin
            ts_upper = `CAD_TS_UPPER_HIGH;
            ts_known = 1'b1;
         end
         default: begin
            ts_upper = `CAD_TS_UPPER_LOW;
            ts_known = 1'b0;
         end
      endcase // RULE_05
      ts_addr = {ts_upper, sensor_sel_cap == `CAD_SEL_HIGH,
                 sensor_slot_cap, sensor_sel_cap == `CAD_SEL_FLOAT}; // RULE_06 RULE_07
      match.scratch = addr_byte[7:1] == mem_base; // RULE_02 RULE_04
      match.info    = addr_byte[7:1] == (mem_base | 7'h01); // RULE_02
      match.sensor  = ts_known && (addr_byte[7:1] == ts_addr); // RULE_04
   end
endmodule
`default_nettype wire

/* cad_top.sv */
// Management bus slave front end for a processor cartridge: decodes the
// address byte for scratch memory, information memory and thermal sensor,
// acknowledges a match and holds the sensor's pending command byte.
// Assumes SCL and SDA arrive asynchronously and are far slower than REF_CLK.
//
// Behaviour
// RULE_01 - Memory components answer only addresses with upper nibble 1010.
// RULE_02 - Address bit 1 picks scratch memory (0) or information memory (1).
// RULE_03 - Memory address bits 3 and 2 follow high and low slot selects.
// RULE_04 - Bit 0 is the read/write flag and never takes part in matching.
// RULE_05 - Sensor decodes one upper pattern 0011, 1001 or 0101 by its select.
// RULE_06 - Select low gives 0011, floating gives 0101 with bit1, high 1001 bit3.
// RULE_07 - Sensor bit 2 follows the slot select, giving six sensor addresses.
// RULE_08 - Sensor captures both selects once at power up and keeps them.
// RULE_09 - The master never issues addresses with upper nibble 0000.
// RULE_10 - The system drives slot selects to firm levels; undriven reads low.
// RULE_11 - Sensor select drivers are valid before the bus supply ramps.
// RULE_12 - Software derives the sensor address from the slot position.
// RULE_13 - Pending sensor command resets to 00h and is invalid until written.
// RULE_14 - A non-matching component gives no acknowledge and idles until start.
`include "cad_defs.svh"
`default_nettype none
module cad_top (
   // Clock, enable and reset
   input  wire logic               REF_CLK,
   input  wire logic               CE,
   input  wire logic               ARST_N,
   // Serial bus pins
   input  wire logic               SCL_IN,
   input  wire logic               SDA_IN,
   output logic                    SDA_OUT,
   output logic                    SDA_OE,
   // Address select pins
   input  wire logic               SLOT_SELECT_HIGH,
   input  wire logic               SLOT_SELECT_LOW,
   input  wire cad_pkg::cad_tsel_t SENSOR_TRISTATE_SELECT,
   // Decode status
   output cad_pkg::cad_match_t     SELECTED,
   output logic                    XFER_READ,
   output logic                    STRAP_DONE,
   // Sensor command
   output logic [7:0]              PENDING_CMD,
   output logic                    CMD_VALID
);
   import cad_pkg::*;

   logic       rst_meta_reg;
   logic       rst_n_reg;
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic [1:0] settle_reg;
   cad_tsel_t  sensor_sel_reg;
   logic       sensor_slot_reg;
   cad_state_t state_reg;
   cad_state_t state_next;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] addr_byte;
   cad_match_t match;
   logic       any_match;
   logic       ack_end;

   // Reset is released through two flops so every flop leaves reset together.
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else if (CE) begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // Pin synchronisers; the first rank feeds only the second.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sync1_reg    <= 6'h3;
         sync2_reg    <= 6'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else if (CE) begin
         sync1_reg    <= {SENSOR_TRISTATE_SELECT, SLOT_SELECT_HIGH,
                          SLOT_SELECT_LOW, SCL_IN, SDA_IN};
         sync2_reg    <= sync1_reg;
         scl_prev_reg <= sync2_reg[1];
         sda_prev_reg <= sync2_reg[0];
      end
   end

   assign scl        = sync2_reg[1];
   assign sda        = sync2_reg[0];
   assign scl_rise   = scl && !scl_prev_reg;
   assign scl_fall   = !scl && scl_prev_reg;
   assign start_cond = scl && scl_prev_reg && !sda && sda_prev_reg;
   assign stop_cond  = scl && scl_prev_reg && sda && !sda_prev_reg;

   // The sensor selects are caught once, after the synchronisers have filled with
   // real pin levels; later pin changes are ignored until the next reset.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         settle_reg      <= 2'h0;
         sensor_sel_reg  <= `CAD_SEL_LOW;
         sensor_slot_reg <= 1'b0;
         STRAP_DONE      <= 1'b0;
      end else if (CE && !STRAP_DONE) begin
         if (settle_reg == `CAD_STRAP_SETTLE) begin
            sensor_sel_reg  <= sync2_reg[5:4]; // RULE_08
            sensor_slot_reg <= sync2_reg[3]; // RULE_08
            STRAP_DONE      <= 1'b1;
         end else begin
            settle_reg <= settle_reg + 2'h1;
         end
      end
   end

   assign addr_byte = shift_reg;
   assign any_match = |match;
   assign ack_end   = scl_fall && SDA_OE;

   cad_addr_match u_match (
      .addr_byte        (addr_byte),
      .slot_select_high (sync2_reg[3]),
      .slot_select_low  (sync2_reg[2]),
      .sensor_sel_cap   (sensor_sel_reg),
      .sensor_slot_cap  (sensor_slot_reg),
      .match            (match)
   );

   // Bytes are shifted in on SCL rising edges while the line is stable.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 4'h0;
      end else if (CE) begin
         if (start_cond || state_reg == CAD_ACK || state_reg == CAD_CACK) begin
            bit_cnt_reg <= 4'h0;
         end else if (scl_rise && bit_cnt_reg != `CAD_BYTE_BITS) begin
            shift_reg   <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end
   end

   // A match comes from the byte as it stands after the eighth bit, so the
   // compare uses the shifted value one cycle after the last edge.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CAD_IDLE, CAD_WAIT: begin
            if (start_cond) begin
               state_next = CAD_ADDR; // RULE_14
            end
         end
         CAD_ADDR: begin
            if (bit_cnt_reg == `CAD_BYTE_BITS) begin
               if (STRAP_DONE && any_match) begin
                  state_next = CAD_ACK;
               end else begin
                  state_next = CAD_WAIT; // RULE_14
               end
            end
         end
         CAD_ACK: begin
            if (ack_end) begin
               state_next = (SELECTED.sensor && !XFER_READ) ? CAD_DATA
                                                            : CAD_WAIT;
            end
         end
         CAD_DATA: begin
            if (bit_cnt_reg == `CAD_BYTE_BITS) begin
               state_next = CAD_CACK;
            end
         end
         CAD_CACK: begin
            if (ack_end) begin
               state_next = CAD_WAIT;
            end
         end
         default: state_next = CAD_IDLE;
      endcase
      if (stop_cond) begin
         state_next = CAD_IDLE;
      end else if (start_cond) begin
         state_next = CAD_ADDR;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= CAD_IDLE;
      end else if (CE) begin
         state_reg <= state_next;
      end
   end

   // Selection flags stand from the address acknowledge to the next start
   // or stop condition.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         SELECTED  <= '0;
         XFER_READ <= 1'b0;
      end else if (CE) begin
         if (start_cond || stop_cond) begin
            SELECTED  <= '0;
            XFER_READ <= 1'b0;
         end else if (state_reg == CAD_ADDR && state_next == CAD_ACK) begin
            SELECTED  <= match;
            XFER_READ <= addr_byte[`CAD_RW_BIT]; // RULE_04
         end
      end
   end

   // Acknowledge: pull SDA low from the falling edge after the eighth bit
   // to the following falling edge. Nothing is driven on a miss.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         SDA_OUT <= 1'b0;
         SDA_OE  <= 1'b0;
      end else if (CE) begin
         SDA_OUT <= 1'b0;
         if (start_cond || stop_cond || ack_end) begin
            SDA_OE <= 1'b0;
         end else if (scl_fall &&
                      (state_reg == CAD_ACK || state_reg == CAD_CACK)) begin
            SDA_OE <= 1'b1; // RULE_14
         end
      end
   end

   // The command byte only counts once it has been acknowledged; until then
   // a receive-byte transfer would see the reserved reset value.
   always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         PENDING_CMD <= `CAD_CMD_RESET; // RULE_13
         CMD_VALID   <= 1'b0; // RULE_13
      end else if (CE && state_reg == CAD_CACK && ack_end) begin
         PENDING_CMD <= shift_reg;
         CMD_VALID   <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* cad_top_chk.sv */
// Port-level checker for the cartridge address decoder.
// Assumes it is bound to cad_top and sees only that module's ports.
`default_nettype none
module cad_top_chk (
   // Clock and reset
   input wire logic                REF_CLK,
   input wire logic                ARST_N,
   // Bus pins
   input wire logic                SCL_IN,
   input wire logic                SDA_OE,
   // Status
   input wire cad_pkg::cad_match_t SELECTED,
   input wire logic                XFER_READ,
   input wire logic                STRAP_DONE,
   input wire logic [7:0]          PENDING_CMD,
   input wire logic                CMD_VALID
);
   timeunit 1ns;
   timeprecision 1ps;
   import cad_pkg::*;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!ARST_N);

   property p_cmd_rst;
      !CMD_VALID |-> PENDING_CMD == 8'h00;
   endproperty
   property p_cmd_src;
      $rose(CMD_VALID) |-> SELECTED.sensor && !XFER_READ;
   endproperty
   property p_strap_keep;
      STRAP_DONE |=> STRAP_DONE;
   endproperty
   property p_no_early;
      !STRAP_DONE |-> !SDA_OE && !(|SELECTED);
   endproperty
   property p_onehot;
      $onehot0(SELECTED);
   endproperty
   property p_ack_owner;
      $rose(SDA_OE) |-> |SELECTED;
   endproperty
   // The acknowledge may only start while the bus clock is low.
   property p_ack_low;
      $rose(SDA_OE) |-> !SCL_IN;
   endproperty
   property p_ack_rel;
      SDA_OE && $fell(SCL_IN) |-> ##[1:8] !SDA_OE;
   endproperty

   a_cmd_rst: assert property (p_cmd_rst)
      else $error("Command changed without a write.");
   a_cmd_src: assert property (p_cmd_src)
      else $error("Command taken outside a sensor write.");
   a_strap_keep: assert property (p_strap_keep)
      else $error("Strap capture flag dropped.");
   a_no_early: assert property (p_no_early)
      else $error("Claim before strap capture.");
   a_onehot: assert property (p_onehot)
      else $error("Several components claimed one address.");
   a_ack_owner: assert property (p_ack_owner)
      else $error("Acknowledge without a claim.");
   a_ack_low: assert property (p_ack_low)
      else $error("Acknowledge started with clock high.");
   a_ack_rel: assert property (p_ack_rel)
      else $error("Acknowledge not released.");

   c_sensor: cover property ($rose(SELECTED.sensor));
   c_info: cover property ($rose(SELECTED.info));
   c_cmd: cover property ($rose(CMD_VALID));
endmodule

bind cad_top cad_top_chk u_chk (
   .REF_CLK(REF_CLK), .ARST_N(ARST_N), .SCL_IN(SCL_IN),
   .SDA_OE(SDA_OE), .SELECTED(SELECTED), .XFER_READ(XFER_READ),
   .STRAP_DONE(STRAP_DONE), .PENDING_CMD(PENDING_CMD),
   .CMD_VALID(CMD_VALID)
);
`default_nettype wire

/* cad_bus_master.sv */
// Behavioural management bus master for the decoder's bus pins.
// Assumes a pull-up on SDA: the line is low only when someone pulls it.
`default_nettype none
module cad_bus_master #(
   parameter int HALF = 10
) (
   // Clock and slave pull-down
   input wire logic clk,
   input wire logic sda_pull,
   // Resolved bus lines
   output var logic scl,
   output var logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sda_drv;

   // A released line floats up to the pull-up level.
   assign sda = sda_drv & ~sda_pull;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic hold();
      repeat (HALF) @(posedge clk);
   endtask

   // Also serves as a repeated start when entered with the clock low.
   task automatic start();
      sda_drv <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b0;
   endtask

   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         hold();
         sda_drv <= b[i];
         hold();
         scl <= 1'b1;
         hold();
         scl <= 1'b0;
      end
      hold();
      sda_drv <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      ack = ~sda;
      scl <= 1'b0;
   endtask

   task automatic stop();
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b1;
      hold();
   endtask
endmodule
`default_nettype wire

/* tb_cartridge_smbus_address_decode.sv */
// Self-checking bench for the cartridge address decoder.
// Assumes cad_top, its checker and the bus master model are compiled first.
`default_nettype none
`define TB_CHK(n, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("Error %s expected %0h seen %0h", n, e, g); \
   end \
end
module tb_cartridge_smbus_address_decode;
   timeunit 1ns;
   timeprecision 1ps;
   import cad_pkg::*;
   logic       ref_clk = 1'b0;
   logic       arst_n;
   logic       ssh;
   logic       ssl;
   cad_tsel_t  tsel;
   logic       scl;
   logic       sda;
   logic       sda_oe;
   logic       sda_out;
   cad_match_t sel;
   logic       xfer_read;
   logic       strap_done;
   logic [7:0] pend;
   logic       cmd_valid;
   int         bad_count = 0;
   int         total_checks = 0;

   always #2.5 ref_clk = ~ref_clk;

   cad_top u_dut (
      .REF_CLK(ref_clk), .CE(1'b1), .ARST_N(arst_n), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .SLOT_SELECT_HIGH(ssh),
      .SLOT_SELECT_LOW(ssl), .SENSOR_TRISTATE_SELECT(tsel),
      .SELECTED(sel), .XFER_READ(xfer_read), .STRAP_DONE(strap_done),
      .PENDING_CMD(pend), .CMD_VALID(cmd_valid)
   );
   // The pad only pulls low when enabled and driving a zero, so a wrong
   // output level shows up as a missing acknowledge.
   cad_bus_master u_mst (
      .clk(ref_clk), .sda_pull(sda_oe & ~sda_out), .scl(scl), .sda(sda)
   );

   task automatic print_verdict();
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic [7:0] sens_addr(input int t, input logic s);
      case (t)
         0: return {4'h3, 1'b0, s, 2'h0};
         1: return {4'h5, 1'b0, s, 2'h2};
         default: return {4'h9, 1'b1, s, 2'h0};
      endcase
   endfunction

   // Straps are settled while reset is held so the capture sees them.
   task automatic reset_dut(input cad_tsel_t t, input logic s);
      int n;
      arst_n <= 1'b0;
      tsel <= t;
      ssh <= s;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      n = 0;
      while (strap_done !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 50) begin
         bad_count++;
         print_verdict();
      end
   endtask

   task automatic sc_memory();
      logic       ack;
      logic [7:0] a;
      for (int s = 0; s < 4; s++) begin
         {ssh, ssl} <= 2'(s);
         for (int k = 0; k < 16; k++) begin
            a = {4'hA, 4'(k)};
            u_mst.start();
            u_mst.send(a, ack);
            `TB_CHK("mem ack", a[3:2] == 2'(s), ack)
            `TB_CHK("scratch", ack & ~a[1], sel.scratch)
            `TB_CHK("info", ack & a[1], sel.info)
            if (ack === 1'b1) `TB_CHK("rw", a[0], xfer_read)
            u_mst.stop();
         end
      end
      `TB_CHK("idle", 3'h0, sel)
   endtask

   task automatic sc_sensor();
      logic       ack;
      logic [7:0] a;
      for (int t = 0; t < 4; t++) begin
         for (int s = 0; s < 2; s++) begin
            reset_dut(2'(t), s[0]);
            tsel <= 2'(t + 1);
            ssh <= ~s[0];
            for (int c = 0; c < 6; c++) begin
               a = sens_addr(c / 2, c[0]) | 8'h01;
               u_mst.start();
               u_mst.send(a, ack);
               `TB_CHK("sensor ack", t == c / 2 && s == c % 2, ack)
               `TB_CHK("sensor sel", ack, sel.sensor)
               u_mst.stop();
            end
         end
      end
   endtask

   task automatic sc_command();
      logic ack;
      reset_dut(2'h0, 1'b0);
      `TB_CHK("cmd reset", 8'h00, pend)
      `TB_CHK("cmd valid", 1'b0, cmd_valid)
      u_mst.start();
      u_mst.send(8'h50, ack);
      `TB_CHK("foreign", 1'b0, ack)
      // Our own address as a data byte must be ignored until a start.
      u_mst.send(8'h30, ack);
      `TB_CHK("ignored", 1'b0, ack)
      u_mst.start();
      u_mst.send(8'h30, ack);
      `TB_CHK("sensor write", 1'b1, ack)
      u_mst.send(8'h0F, ack);
      `TB_CHK("cmd ack", 1'b1, ack)
      u_mst.stop();
      `TB_CHK("cmd", 8'h0F, pend)
      `TB_CHK("cmd set", 1'b1, cmd_valid)
      `TB_CHK("sel clear", 3'h0, sel)
   endtask

   initial begin
      arst_n = 1'b0;
      ssh = 1'b0;
      ssl = 1'b0;
      tsel = 2'h0;
      reset_dut(2'h0, 1'b0);
      sc_memory();
      sc_sensor();
      sc_command();
      print_verdict();
   end
endmodule
`default_nettype wire
